/* hw/digital_input_conditioning.sv */
// How it works
// [RULE_01] Inputs six to ten select function 0-99
// [RULE_02] Inputs nine and ten are high-speed; code here gives fast filter to inputs six-ten with code 34 or 40
// [RULE_03] Fast filter 1-32767 us, reset 10
// [RULE_04] Codes 34 and 40 use fast filter
// [RULE_05] Slow filter 1-32767 us, reset 1000
// [RULE_06] Inputs one to five have polarity
// [RULE_07] Read-only valid-state vector, bit0 is input1
// [RULE_08] Read-only raw terminal level vector
// [RULE_09] Forced mask bit forces input ON
// [RULE_10] Function codes decode to drive actions
// [RULE_11] Output changes after level held filter time
// [RULE_12] Valid is polarity-filtered OR forced
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module digital_input_conditioning
	import di_cond_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [NUM_INPUTS-1:0] digital_input_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [NUM_INPUTS-1:0] valid_state_vector,
	output logic [NUM_INPUTS-1:0] raw_level_vector,
	output drive_actions_s drive_actions
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [NUM_INPUTS-1:0] sync1_reg;
	logic [NUM_INPUTS-1:0] sync2_reg;
	logic [CODE_W-1:0] func_reg [5];
	logic [NUM_INPUTS-1:0] forced_input_vector;
	logic [FILT_W-1:0] fast_filter_time;
	logic [FILT_W-1:0] slow_filter_time;
	logic [4:0] polarity_reg;
	logic [5:0] tick_cnt_reg;
	logic us_tick;
	logic [NUM_INPUTS-1:0] filtered;
	logic [NUM_INPUTS-1:0] polar;
	logic [NUM_INPUTS-1:0] valid_next;
	logic [7:0] aw_addr_reg;
	logic aw_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_held_reg;
	logic wr_go;
	logic wr_err;
	logic [31:0] rd_data;
	logic rd_err;

	function automatic logic [CODE_W-1:0] func_of(input int idx);
		// Inputs one to five carry no selector here
		if (idx < 5) begin
			func_of = FUNC_RESET;
		end else begin
			func_of = func_reg[idx-5];
		end
	endfunction

	function automatic logic uses_fast(input logic [CODE_W-1:0] code);
		uses_fast = (code == FC_HOME_SWITCH) || (code == FC_TRIG_FIXED_LEN); // [RULE_04]
	endfunction

	function automatic logic [FILT_W-1:0] clamp_time(input logic [31:0] d);
		if (d[FILT_W-1:0] < FILT_MIN) begin
			clamp_time = FILT_MIN;
		end else begin
			clamp_time = d[FILT_W-1:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= digital_input_n;
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------------------------------
	// Microsecond tick
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_reg <= '0;
		end else if (tick_cnt_reg == 6'(CYCLES_PER_US - 1)) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 6'h01;
		end
	end

	assign us_tick = (tick_cnt_reg == 6'(CYCLES_PER_US - 1));

	// ----------------------------------------------------------------
	// Per-input filters
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_filt
		logic [FILT_W-1:0] sel_time;
		// Any of inputs six to ten takes the fast filter when its code is 34 or 40
		// A process, so a rewritten code retimes the filter at once
		always_comb begin
			if (uses_fast(func_of(i))) begin // [RULE_02]
				sel_time = fast_filter_time; // [RULE_04]
			end else begin
				sel_time = slow_filter_time; // [RULE_04]
			end
		end
		input_filter u_filt (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.us_tick(us_tick),
			.raw_in(sync2_reg[i]),
			.filt_time(sel_time),
			.filt_out(filtered[i])
		);
	end

	// ----------------------------------------------------------------
	// Polarity and forcing
	// ----------------------------------------------------------------
	always_comb begin
		polar = filtered;
		for (int i = 0; i < 5; i++) begin
			polar[i] = polarity_reg[i] ? filtered[i] : ~filtered[i]; // [RULE_06]
		end
		valid_next = polar | forced_input_vector; // [RULE_12] [RULE_09]
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			valid_state_vector <= '0;
			raw_level_vector <= '0;
		end else begin
			valid_state_vector <= valid_next; // [RULE_07]
			raw_level_vector <= sync2_reg; // [RULE_08]
		end
	end

	// ----------------------------------------------------------------
	// Function decode
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			drive_actions <= '0;
		end else begin
			drive_actions <= '0;
			for (int i = 5; i < NUM_INPUTS; i++) begin
				if (valid_next[i]) begin
					case (func_reg[i-5])
						FC_CLEAR_ENCODER: drive_actions.clear_encoder <= 1'b1; // [RULE_10]
						FC_HOME_SWITCH: drive_actions.home_switch <= 1'b1;
						FC_TRIG_FIXED_LEN: drive_actions.trig_fixed_len <= 1'b1;
						FC_RESET_FAULT: drive_actions.reset_fault <= 1'b1;
						default: ;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (wr_go) begin
			aw_held_reg <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_held_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (wr_go) begin
			w_held_reg <= 1'b0;
		end else begin
			s_axi_wready <= !w_held_reg && !s_axi_bvalid;
		end
	end

	always_comb begin
		if (aw_addr_reg >= ADDR_FUNC6 && aw_addr_reg <= ADDR_FUNC10) begin
			wr_err = 1'b0;
		end else if (aw_addr_reg == ADDR_FORCE || aw_addr_reg == ADDR_FAST_FILT) begin
			wr_err = 1'b0;
		end else if (aw_addr_reg == ADDR_SLOW_FILT) begin
			wr_err = 1'b0;
		end else if (aw_addr_reg >= ADDR_POL1 && aw_addr_reg <= ADDR_POL5) begin
			wr_err = 1'b0;
		end else begin
			wr_err = 1'b1;
		end
		if (aw_addr_reg[1:0] != 2'h0) begin
			wr_err = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Parameter registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 5; i++) begin
				func_reg[i] <= FUNC_RESET; // [RULE_01]
			end
			forced_input_vector <= FORCE_RESET;
			fast_filter_time <= FAST_FILT_RESET; // [RULE_03]
			slow_filter_time <= SLOW_FILT_RESET; // [RULE_05]
			polarity_reg <= POL_RESET;
		end else if (wr_go && !wr_err && w_strb_reg[0]) begin
			if (aw_addr_reg <= ADDR_FUNC10) begin
				// Out-of-range codes are ignored
				if (w_data_reg[15:0] <= 16'(FUNC_MAX)) begin
					func_reg[aw_addr_reg[4:2]] <= w_data_reg[CODE_W-1:0]; // [RULE_01]
				end
			end else if (aw_addr_reg == ADDR_FORCE) begin
				if (w_strb_reg[1]) begin
					forced_input_vector <= w_data_reg[9:0]; // [RULE_09]
				end
			end else if (aw_addr_reg == ADDR_FAST_FILT) begin
				if (w_strb_reg[1]) begin
					fast_filter_time <= clamp_time(w_data_reg); // [RULE_03]
				end
			end else if (aw_addr_reg == ADDR_SLOW_FILT) begin
				if (w_strb_reg[1]) begin
					slow_filter_time <= clamp_time(w_data_reg); // [RULE_05]
				end
			end else begin
				polarity_reg[3'(aw_addr_reg[5:2] - 4'ha)] <= w_data_reg[0]; // [RULE_06]
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		if (s_axi_araddr >= ADDR_FUNC6 && s_axi_araddr <= ADDR_FUNC10) begin
			rd_data[CODE_W-1:0] = func_reg[s_axi_araddr[4:2]];
		end else if (s_axi_araddr == ADDR_VALID) begin
			rd_data[9:0] = valid_state_vector; // [RULE_07]
		end else if (s_axi_araddr == ADDR_FORCE) begin
			rd_data[9:0] = forced_input_vector;
		end else if (s_axi_araddr == ADDR_RAW) begin
			rd_data[9:0] = raw_level_vector; // [RULE_08]
		end else if (s_axi_araddr == ADDR_FAST_FILT) begin
			rd_data[FILT_W-1:0] = fast_filter_time;
		end else if (s_axi_araddr == ADDR_SLOW_FILT) begin
			rd_data[FILT_W-1:0] = slow_filter_time;
		end else if (s_axi_araddr >= ADDR_POL1 && s_axi_araddr <= ADDR_POL5) begin
			rd_data[0] = polarity_reg[3'(s_axi_araddr[5:2] - 4'ha)];
		end else begin
			rd_err = 1'b1;
		end
		if (s_axi_araddr[1:0] != 2'h0) begin
			rd_err = 1'b1;
			rd_data = '0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

/* hw/di_cond_pkg.sv */
package di_cond_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int NUM_INPUTS = 10;
	localparam int CODE_W = 7;
	localparam int FILT_W = 15;
	localparam int CLK_HZ = 50000000;
	localparam int US_PER_S = 1000000;
	localparam int CYCLES_PER_US = CLK_HZ / US_PER_S;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_FUNC6 = 8'h00;
	localparam logic [7:0] ADDR_FUNC7 = 8'h04;
	localparam logic [7:0] ADDR_FUNC8 = 8'h08;
	localparam logic [7:0] ADDR_FUNC9 = 8'h0c;
	localparam logic [7:0] ADDR_FUNC10 = 8'h10;
	localparam logic [7:0] ADDR_VALID = 8'h14;
	localparam logic [7:0] ADDR_FORCE = 8'h18;
	localparam logic [7:0] ADDR_RAW = 8'h1c;
	localparam logic [7:0] ADDR_FAST_FILT = 8'h20;
	localparam logic [7:0] ADDR_SLOW_FILT = 8'h24;
	localparam logic [7:0] ADDR_POL1 = 8'h28;
	localparam logic [7:0] ADDR_POL5 = 8'h38;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [CODE_W-1:0] FUNC_RESET = 7'h00;
	localparam logic [CODE_W-1:0] FUNC_MAX = 7'h63;
	localparam logic [9:0] FORCE_RESET = 10'h000;
	localparam logic [FILT_W-1:0] FAST_FILT_RESET = 15'h000a;
	localparam logic [FILT_W-1:0] SLOW_FILT_RESET = 15'h03e8;
	localparam logic [FILT_W-1:0] FILT_MIN = 15'h0001;
	localparam logic [4:0] POL_RESET = 5'h00;

	// ----------------------------------------------------------------
	// Function codes
	// ----------------------------------------------------------------
	localparam logic [CODE_W-1:0] FC_CLEAR_ENCODER = 7'h0f;
	localparam logic [CODE_W-1:0] FC_HOME_SWITCH = 7'h22;
	localparam logic [CODE_W-1:0] FC_TRIG_FIXED_LEN = 7'h28;
	localparam logic [CODE_W-1:0] FC_RESET_FAULT = 7'h2a;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic clear_encoder;
		logic home_switch;
		logic trig_fixed_len;
		logic reset_fault;
	} drive_actions_s;

endpackage

/* hw/input_filter.sv */
`timescale 1ns/100ps
`default_nettype none

module input_filter
	import di_cond_pkg::*;
#(
	parameter int TICK_DIV = CYCLES_PER_US
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic us_tick,
	input wire logic raw_in,
	input wire logic [FILT_W-1:0] filt_time,
	output logic filt_out
);

	logic [FILT_W-1:0] count_reg;

	// ----------------------------------------------------------------
	// Hold-time qualification
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
			filt_out <= 1'b0;
		end else if (raw_in == filt_out) begin
			count_reg <= '0; // [RULE_11]
		end else if (us_tick) begin
			if (count_reg + FILT_MIN >= filt_time) begin
				filt_out <= raw_in; // [RULE_11]
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + FILT_MIN;
			end
		end
	end

endmodule

`default_nettype wire

/* dv/digital_input_conditioning_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

module digital_input_conditioning_monitor
	import di_cond_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [NUM_INPUTS-1:0] digital_input_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_INPUTS-1:0] valid_state_vector,
	input wire logic [NUM_INPUTS-1:0] raw_level_vector,
	input wire drive_actions_s drive_actions
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	raw_follows_a: assert property ($stable(digital_input_n)[*5]
		|-> raw_level_vector == digital_input_n)
		else $error("raw level does not follow terminals");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	read_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	busy_ready_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("ready while busy");
	action_source_a: assert property (drive_actions != 4'h0
		|-> (valid_state_vector[9:5] | $past(valid_state_vector[9:5])) != 5'h00)
		else $error("action without active input");
endmodule

bind digital_input_conditioning digital_input_conditioning_monitor u_monitor (
	.ref_clk, .reset_n, .digital_input_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .valid_state_vector, .raw_level_vector, .drive_actions
);

`default_nettype wire

/* dv/terminal_model.sv */
`timescale 1ns/100ps
`default_nettype none

module terminal_model
	import di_cond_pkg::*;
(
	input wire logic [NUM_INPUTS-1:0] level,
	input wire logic [NUM_INPUTS-1:0] spike,
	output logic [NUM_INPUTS-1:0] digital_input_n
);
	// ----------------------------------------------------------------
	// Switch contacts, with commanded spikes inverting the level
	// ----------------------------------------------------------------
	assign digital_input_n = level ^ spike;
endmodule

`default_nettype wire

/* dv/test_digital_input_conditioning.sv */
`timescale 1ns/100ps
`default_nettype none

module test_digital_input_conditioning;
	import di_cond_pkg::*;
	logic ref_clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [9:0] level = 0, spike = 0, frc, digital_input_n, valid_state_vector, raw_level_vector;
	logic [4:0] pol;
	drive_actions_s drive_actions;
	int failures = 0, tests_run = 0, seed;

	// ----------------------------------------------------------------
	// Clock, partner and design
	// ----------------------------------------------------------------
	initial forever #10 ref_clk = ~ref_clk;
	terminal_model u_terminal_model (.level, .spike, .digital_input_n);
	digital_input_conditioning u_digital_input_conditioning (.ref_clk, .reset_n, .digital_input_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.valid_state_vector, .raw_level_vector, .drive_actions);

	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] r);
		logic ta, tw;
		ta = 0;
		tw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ta && tw)) begin
			@(posedge ref_clk);
			if (!ta && s_axi_awready) begin
				ta = 1;
				s_axi_awvalid <= 0;
			end
			if (!tw && s_axi_wready) begin
				tw = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge ref_clk);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] rdv, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		rdv = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge ref_clk);
	endtask

	function automatic logic [31:0] rst_val(input logic [7:0] a);
		return (a == ADDR_FAST_FILT) ? 32'h0000000a : (a == ADDR_SLOW_FILT) ? 32'h000003e8 : 32'h0;
	endfunction

	function automatic logic [9:0] exp_valid(input logic [9:0] lv, input logic [4:0] p,
		input logic [9:0] f);
		return {lv[9:5], ~(lv[4:0] ^ p)} | f;
	endfunction

	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		give_verdict;
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		seed = $urandom(75);
		repeat (5) @(posedge ref_clk);
		reset_n <= 1;
		repeat (2) @(posedge ref_clk);
		for (int a = 0; a < 'h3c; a += 4) begin
			if (a != 'h14 && a != 'h1c) begin
				rd(8'(a), d, rs);
				chk(d, rst_val(8'(a)));
				chk(rs, RESP_OKAY);
			end
		end
		$display("Test reset values done");
		wr(ADDR_SLOW_FILT, 32'h8, rs);
		wr(ADDR_FAST_FILT, 32'h0, rs);
		rd(ADDR_FAST_FILT, d, rs);
		chk(d, 32'h1);
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 32'd99 : $urandom_range(99);
			wr(ADDR_FUNC6 + 8'(4 * i), v, rs);
			wr(ADDR_FUNC6 + 8'(4 * i), 32'd100 + $urandom_range(27), rs);
			chk(rs, RESP_OKAY);
			rd(ADDR_FUNC6 + 8'(4 * i), d, rs);
			chk(d, v);
		end
		wr(ADDR_VALID, 32'h3ff, rs);
		chk(rs, RESP_SLVERR);
		rd(8'h3c, d, rs);
		chk(d, 32'h0);
		chk(rs, RESP_SLVERR);
		$display("Test register access done");
		wr(ADDR_FUNC6, 32'h0, rs);
		wr(ADDR_FUNC9, 32'(FC_HOME_SWITCH), rs);
		wr(ADDR_FUNC10, 32'(FC_TRIG_FIXED_LEN), rs);
		for (int k = 0; k < 4; k++) begin
			level <= 10'($urandom);
			pol = 5'($urandom);
			frc = (k == 0) ? 10'h0 : 10'($urandom);
			for (int i = 0; i < 5; i++) wr(ADDR_POL1 + 8'(4 * i), {31'h0, pol[i]}, rs);
			wr(ADDR_FORCE, {22'h0, frc}, rs);
			repeat (600) @(posedge ref_clk);
			chk(valid_state_vector, exp_valid(level, pol, frc));
			chk(raw_level_vector, level);
			rd(ADDR_VALID, d, rs);
			chk(d, exp_valid(level, pol, frc));
			rd(ADDR_RAW, d, rs);
			chk(d, level);
		end
		$display("Test levels done");
		wr(ADDR_FORCE, 32'h0, rs);
		level <= 10'h0;
		repeat (600) @(posedge ref_clk);
		spike <= 10'h120;
		repeat (200) @(posedge ref_clk);
		chk(valid_state_vector[8], 1'b1);
		chk(valid_state_vector[5], 1'b0);
		chk(drive_actions.home_switch, 1'b1);
		spike <= 10'h0;
		repeat (300) @(posedge ref_clk);
		chk(valid_state_vector[9:5], 5'h00);
		$display("Test spikes done");
		wr(ADDR_FUNC6, 32'(FC_RESET_FAULT), rs);
		wr(ADDR_FUNC7, 32'(FC_CLEAR_ENCODER), rs);
		wr(ADDR_FORCE, 32'h3e0, rs);
		repeat (5) @(posedge ref_clk);
		chk(drive_actions, 4'hf);
		wr(ADDR_FORCE, 32'h200, rs);
		repeat (5) @(posedge ref_clk);
		chk(drive_actions, 4'h2);
		$display("Test decode done");
		give_verdict;
	end
endmodule

`default_nettype wire
